// file: dhs_consts.svh
`ifndef DHS_CONSTS_SVH
`define DHS_CONSTS_SVH

`define DHS_ADDR_W          12
`define DHS_OFF_BEGIN       12'h000
`define DHS_OFF_HALT        12'h004
`define DHS_OFF_EVENT       12'h100
`define DHS_OFF_IRQ_SET     12'h304
`define DHS_OFF_IRQ_CLR     12'h308
`define DHS_OFF_RESULT      12'h508
`define DHS_OFF_SLOPE_1     12'h520
`define DHS_OFF_SLOPE_2     12'h524
`define DHS_OFF_SLOPE_3     12'h528
`define DHS_OFF_SLOPE_4     12'h52C
`define DHS_OFF_SLOPE_5     12'h530
`define DHS_OFF_SLOPE_6     12'h534
`define DHS_OFF_ICEPT_1     12'h540
`define DHS_OFF_ICEPT_2     12'h544
`define DHS_OFF_ICEPT_3     12'h548
`define DHS_OFF_ICEPT_4     12'h54C
`define DHS_OFF_ICEPT_5     12'h550
`define DHS_OFF_ICEPT_6     12'h554
`define DHS_OFF_ENDPT_1     12'h560
`define DHS_OFF_ENDPT_2     12'h564
`define DHS_OFF_ENDPT_3     12'h568
`define DHS_OFF_ENDPT_4     12'h56C
`define DHS_OFF_ENDPT_5     12'h570

`define DHS_RST_SLOPE_1     32'h0000_0326
`define DHS_RST_SLOPE_2     32'h0000_0348
`define DHS_RST_SLOPE_3     32'h0000_03AA
`define DHS_RST_SLOPE_4     32'h0000_040E
`define DHS_RST_SLOPE_5     32'h0000_04BD
`define DHS_RST_SLOPE_6     32'h0000_05A3
`define DHS_RST_ICEPT_1     32'h0000_3FEF
`define DHS_RST_OTHER       32'h0000_0000
`define DHS_RST_ZERO        32'h0000_0000

`define DHS_BIT_TRIGGER     0
`define DHS_BIT_DONE        0
`define DHS_CAL_N           17
`define DHS_SENSE_W         16
`define DHS_RESP_OKAY       2'h0
`define DHS_RESP_SLVERR     2'h2

`endif

// file: dhs_pkg.sv
package dhs_pkg;

  typedef enum logic [1:0] {
    DHS_IDLE    = 2'b00,
    DHS_CONVERT = 2'b01
  } dhs_state_t;

endpackage

// file: dhs_ctrl.sv
// What this block does
// - Writing 1 to the begin task, or a trigger pulse, starts a conversion.
// - The completion event is raised when the conversion has finished.
// - After completion the measured value is readable as the result.
// - The result counts one quarter degree per least significant bit.
// - On completion the analog front end powers down until the next start.
// - No conversion starts or repeats unless the begin task is fired.
// - The event register reads 1 once raised, else 0; software clears it.
// - Writing 1 to the enable-set bit enables the interrupt; reads give it.
// - Writing 1 to the enable-clear bit disables it; reads give the enable.
// - The result is signed two's complement in quarter degrees Celsius.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/100ps
`include "dhs_consts.svh"

module dhs_ctrl (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [`DHS_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]              s_axi_awprot,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [`DHS_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]              s_axi_arprot,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    begin_measure_trigger,
  input  wire logic                    halt_measure_trigger,
  output logic                         conversion_done,
  output logic                         sense_power_on,
  input  wire logic                    sense_ready,
  input  wire logic [`DHS_SENSE_W-1:0] sense_quarter_deg,
  output logic                         irq
);

  localparam logic [`DHS_ADDR_W-1:0] CAL_OFF [`DHS_CAL_N] = '{
    `DHS_OFF_SLOPE_1, `DHS_OFF_SLOPE_2, `DHS_OFF_SLOPE_3,
    `DHS_OFF_SLOPE_4, `DHS_OFF_SLOPE_5, `DHS_OFF_SLOPE_6,
    `DHS_OFF_ICEPT_1, `DHS_OFF_ICEPT_2, `DHS_OFF_ICEPT_3,
    `DHS_OFF_ICEPT_4, `DHS_OFF_ICEPT_5, `DHS_OFF_ICEPT_6,
    `DHS_OFF_ENDPT_1, `DHS_OFF_ENDPT_2, `DHS_OFF_ENDPT_3,
    `DHS_OFF_ENDPT_4, `DHS_OFF_ENDPT_5
  };

  localparam logic [31:0] CAL_RST [`DHS_CAL_N] = '{
    `DHS_RST_SLOPE_1, `DHS_RST_SLOPE_2, `DHS_RST_SLOPE_3,
    `DHS_RST_SLOPE_4, `DHS_RST_SLOPE_5, `DHS_RST_SLOPE_6,
    `DHS_RST_ICEPT_1, `DHS_RST_OTHER,   `DHS_RST_OTHER,
    `DHS_RST_OTHER,   `DHS_RST_OTHER,   `DHS_RST_OTHER,
    `DHS_RST_OTHER,   `DHS_RST_OTHER,   `DHS_RST_OTHER,
    `DHS_RST_OTHER,   `DHS_RST_OTHER
  };

  dhs_pkg::dhs_state_t         state_r;
  dhs_pkg::dhs_state_t         state_nxt;
  logic                        aw_have_r;
  logic [`DHS_ADDR_W-1:0]      aw_addr_r;
  logic                        w_have_r;
  logic [31:0]                 w_data_r;
  logic [3:0]                  w_strb_r;
  logic                        bvalid_r;
  logic [1:0]                  bresp_r;
  logic                        rvalid_r;
  logic [31:0]                 rdata_r;
  logic [1:0]                  rresp_r;
  logic                        wr_fire;
  logic [`DHS_ADDR_W-1:0]      wr_addr;
  logic                        wr_lane0;
  logic                        wr_hit;
  logic                        rd_fire;
  logic [31:0]                 rd_data;
  logic                        rd_hit;
  logic                        sw_begin;
  logic                        sw_halt;
  logic                        do_begin;
  logic                        do_halt;
  logic                        ready_meta_r;
  logic                        ready_sync_r;
  logic                        ready_prev_r;
  logic                        ready_rise;
  logic                        finish;
  logic                        power_r;
  logic                        done_pulse_r;
  logic                        event_r;
  logic                        irq_en_r;
  logic signed [31:0]          result_r;
  logic [31:0]                 cal_r [`DHS_CAL_N];
  logic [`DHS_CAL_N-1:0]       cal_wr_hit;
  logic [`DHS_CAL_N-1:0]       cal_rd_hit;

  // Write address and data are taken independently, in either order
  assign s_axi_awready = !aw_have_r && !bvalid_r;
  assign s_axi_wready  = !w_have_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  assign wr_fire  = aw_have_r && w_have_r && !bvalid_r;
  assign wr_addr  = {aw_addr_r[`DHS_ADDR_W-1:2], 2'b00};
  assign wr_lane0 = w_strb_r[0];
  assign rd_fire  = s_axi_arvalid && !rvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_r <= 1'b0;
      w_data_r <= `DHS_RST_ZERO;
      w_strb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `DHS_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_hit ? `DHS_RESP_OKAY : `DHS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Task writes act only on a one in the trigger bit
  assign sw_begin = wr_fire && wr_lane0 && (wr_addr == `DHS_OFF_BEGIN)
                    && w_data_r[`DHS_BIT_TRIGGER];
  assign sw_halt  = wr_fire && wr_lane0 && (wr_addr == `DHS_OFF_HALT)
                    && w_data_r[`DHS_BIT_TRIGGER];
  assign do_begin = sw_begin || begin_measure_trigger;
  assign do_halt  = sw_halt || halt_measure_trigger;

  // Front end ready crosses from the analog side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ready_meta_r <= 1'b0;
      ready_sync_r <= 1'b0;
      ready_prev_r <= 1'b0;
    end else begin
      ready_meta_r <= sense_ready;
      ready_sync_r <= ready_meta_r;
      ready_prev_r <= ready_sync_r;
    end
  end

  assign ready_rise = ready_sync_r && !ready_prev_r;
  assign finish     = (state_r == dhs_pkg::DHS_CONVERT) && ready_rise
                      && !do_halt;

  // Halt beats a start or a finish in the same cycle
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      dhs_pkg::DHS_IDLE: begin
        if (do_begin && !do_halt) begin
          state_nxt = dhs_pkg::DHS_CONVERT;
        end
      end
      dhs_pkg::DHS_CONVERT: begin
        if (do_halt) begin
          state_nxt = dhs_pkg::DHS_IDLE;
        end else if (ready_rise) begin
          state_nxt = dhs_pkg::DHS_IDLE;
        end
      end
      default: begin
        state_nxt = dhs_pkg::DHS_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= dhs_pkg::DHS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Power follows the conversion state, off in idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_r <= 1'b0;
    end else begin
      power_r <= (state_nxt == dhs_pkg::DHS_CONVERT);
    end
  end

  assign sense_power_on = power_r;

  // Sample is stable while ready is high, so capture after sync
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_r <= '0;
    end else if (finish) begin
      result_r <= 32'(signed'(sense_quarter_deg));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_pulse_r <= 1'b0;
    end else begin
      done_pulse_r <= finish;
    end
  end

  assign conversion_done = done_pulse_r;

  // Set wins over a clearing write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_r <= 1'b0;
    end else if (finish) begin
      event_r <= 1'b1;
    end else if (wr_fire && wr_lane0 && (wr_addr == `DHS_OFF_EVENT)
                 && w_data_r[`DHS_BIT_DONE]) begin
      event_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en_r <= 1'b0;
    end else if (wr_fire && wr_lane0 && w_data_r[`DHS_BIT_DONE]) begin
      if (wr_addr == `DHS_OFF_IRQ_SET) begin
        irq_en_r <= 1'b1;
      end else if (wr_addr == `DHS_OFF_IRQ_CLR) begin
        irq_en_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= event_r && irq_en_r;
    end
  end

  // Calibration words are plain storage; no arithmetic here
  genvar gi;
  generate
    for (gi = 0; gi < `DHS_CAL_N; gi = gi + 1) begin : g_cal
      assign cal_wr_hit[gi] = wr_fire && (wr_addr == CAL_OFF[gi]);
      assign cal_rd_hit[gi] = ({s_axi_araddr[`DHS_ADDR_W-1:2], 2'b00}
                               == CAL_OFF[gi]);
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cal_r[gi] <= CAL_RST[gi];
        end else if (cal_wr_hit[gi]) begin
          for (int b = 0; b < 4; b++) begin
            if (w_strb_r[b]) begin
              cal_r[gi][b*8 +: 8] <= w_data_r[b*8 +: 8];
            end
          end
        end
      end
    end
  endgenerate

  always_comb begin
    wr_hit = (|cal_wr_hit);
    case (wr_addr)
      `DHS_OFF_BEGIN,
      `DHS_OFF_HALT,
      `DHS_OFF_EVENT,
      `DHS_OFF_IRQ_SET,
      `DHS_OFF_IRQ_CLR,
      `DHS_OFF_RESULT: begin
        wr_hit = 1'b1;
      end
      default: begin
        wr_hit = wr_hit;
      end
    endcase
  end

  // Task registers are write only and read back as zero
  always_comb begin
    rd_data = `DHS_RST_ZERO;
    rd_hit  = 1'b0;
    for (int i = 0; i < `DHS_CAL_N; i++) begin
      if (cal_rd_hit[i]) begin
        rd_data = cal_r[i];
        rd_hit  = 1'b1;
      end
    end
    case ({s_axi_araddr[`DHS_ADDR_W-1:2], 2'b00})
      `DHS_OFF_BEGIN,
      `DHS_OFF_HALT: begin
        rd_hit = 1'b1;
      end
      `DHS_OFF_EVENT: begin
        rd_data[`DHS_BIT_DONE] = event_r;
        rd_hit = 1'b1;
      end
      `DHS_OFF_IRQ_SET,
      `DHS_OFF_IRQ_CLR: begin
        rd_data[`DHS_BIT_DONE] = irq_en_r;
        rd_hit = 1'b1;
      end
      `DHS_OFF_RESULT: begin
        rd_data = result_r;
        rd_hit = 1'b1;
      end
      default: begin
        rd_hit = rd_hit;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= `DHS_RST_ZERO;
      rresp_r  <= `DHS_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_data;
      rresp_r  <= rd_hit ? `DHS_RESP_OKAY : `DHS_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule

// file: dhs_ctrl_assertions.sv
`timescale 1ns/100ps
module dhs_ctrl_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        begin_measure_trigger,
  input wire logic        halt_measure_trigger,
  input wire logic        conversion_done,
  input wire logic        sense_power_on,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // A halt written in the same cycle wins and shows as a write response
  a_start_powers: assert property (
    begin_measure_trigger && !halt_measure_trigger && !sense_power_on
    |=> sense_power_on || $rose(s_axi_bvalid))
    else $error("start did not power up");
  a_done_pulse: assert property (
    conversion_done |-> $past(sense_power_on) ##1 !conversion_done)
    else $error("done pulse wrong");
  a_done_off: assert property (
    conversion_done |-> !sense_power_on) else $error("power left on");
  // Start by register shows up around the write response
  a_no_self_start: assert property (
    $rose(sense_power_on) |->
      $past(begin_measure_trigger) || s_axi_bvalid || $past(s_axi_bvalid))
    else $error("conversion started unasked");
  a_halt_quiet: assert property (
    halt_measure_trigger && sense_power_on
    |=> !sense_power_on && !conversion_done ##1 !conversion_done)
    else $error("halt did not abort");
  a_irq_cause: assert property (
    $rose(irq) |-> $past(conversion_done) || $past(s_axi_bvalid))
    else $error("irq rose without cause");
  a_irq_drop: assert property (
    $fell(irq) |-> $past(s_axi_bvalid)) else $error("irq fell unasked");
  a_write_resp: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response late");
  a_read_resp: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_read_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");

  c_done: cover property (conversion_done);
  c_irq: cover property ($rose(irq));
  c_halt: cover property (halt_measure_trigger && sense_power_on);
endmodule

bind dhs_ctrl dhs_ctrl_checker dhs_ctrl_checker_inst (.*);

// file: tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic        aclk, aresetn = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [15:0] sense_quarter_deg = 16'h0000;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0, sense_ready = 1'h0;
  logic        begin_measure_trigger = 1'h0, halt_measure_trigger = 1'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, conversion_done, sense_power_on, irq;
  int          errors, num_checks, cyc;

  dhs_ctrl dhs_ctrl_inst (.*);

  initial begin
    aclk = 1'h0;
    forever #50 aclk = ~aclk;
  end

  task automatic results;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Far beyond the fewer than two hundred cycles the tests need
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Ready and valid are read at the edge, before the design updates
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er = 2'h0);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [1:0] er = 2'h0);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, e);
    chk(32'(s_axi_rresp), 32'(er));
  endtask

  // Released sample goes to its inverse so stale data cannot pass
  task automatic conv(input logic [15:0] v);
    int n;
    n = 0;
    while (!sense_power_on && n < 20) begin
      @(posedge aclk);
      n++;
    end
    chk(32'(sense_power_on), 32'h1);
    sense_quarter_deg <= v;
    sense_ready <= 1'h1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!conversion_done && n < 20);
    chk(32'(conversion_done), 32'h1);
    chk(32'(sense_power_on), 32'h0);
    sense_ready <= 1'h0;
    sense_quarter_deg <= ~v;
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rd(12'h520, 32'h0000_0326);
    rd(12'h524, 32'h0000_0348);
    rd(12'h528, 32'h0000_03aa);
    rd(12'h52c, 32'h0000_040e);
    rd(12'h530, 32'h0000_04bd);
    rd(12'h534, 32'h0000_05a3);
    rd(12'h540, 32'h0000_3fef);
    rd(12'h100, 32'h0);
    rd(12'h304, 32'h0);
    rd(12'h508, 32'h0);
    rd(12'h000, 32'h0);
    rd(12'h200, 32'h0, 2'h2);
    wr(12'h200, 32'h1, 2'h2);
    wr(12'h570, 32'h1234_5678);
    rd(12'h570, 32'h1234_5678);
    wr(12'h508, 32'h55);
    rd(12'h508, 32'h0);
    $display("test registers done");
    wr(12'h304, 32'h0);
    rd(12'h304, 32'h0);
    wr(12'h304, 32'h1);
    rd(12'h308, 32'h1);
    $display("test enable done");
    wr(12'h000, 32'h1);
    conv(16'hfffb);
    rd(12'h508, 32'hffff_fffb);
    rd(12'h100, 32'h1);
    chk(32'(irq), 32'h1);
    repeat (20) @(posedge aclk);
    chk(32'(sense_power_on), 32'h0);
    $display("test register start done");
    wr(12'h308, 32'h0);
    rd(12'h304, 32'h1);
    wr(12'h100, 32'h1);
    rd(12'h100, 32'h0);
    chk(32'(irq), 32'h0);
    @(posedge aclk) begin_measure_trigger <= 1'h1;
    @(posedge aclk) begin_measure_trigger <= 1'h0;
    conv(16'h0064);
    rd(12'h508, 32'h64);
    chk(32'(irq), 32'h1);
    wr(12'h308, 32'h1);
    rd(12'h304, 32'h0);
    chk(32'(irq), 32'h0);
    $display("test pin start done");
    wr(12'h100, 32'h1);
    @(posedge aclk) begin_measure_trigger <= 1'h1;
    @(posedge aclk) begin_measure_trigger <= 1'h0;
    repeat (3) @(posedge aclk);
    chk(32'(sense_power_on), 32'h1);
    @(posedge aclk) halt_measure_trigger <= 1'h1;
    @(posedge aclk) halt_measure_trigger <= 1'h0;
    repeat (2) @(posedge aclk);
    chk(32'(sense_power_on), 32'h0);
    wr(12'h000, 32'h1);
    wr(12'h004, 32'h1);
    @(posedge aclk);
    chk(32'(sense_power_on), 32'h0);
    rd(12'h100, 32'h0);
    rd(12'h508, 32'h64);
    $display("test halt done");
    results();
  end
endmodule
